// [core/dram_refresh_pkg.sv]
package dram_refresh_pkg;

  localparam int CLOCK_MHZ         = 25;
  localparam int CLOCK_NS          = 40;
  localparam int ADDR_W            = 10;
  localparam int DATA_W            = 16;

  // power-up pause, longer than 4096 cycles so the top takes it as a parameter
  localparam int POWER_WAIT_US     = 200;
  localparam int POWER_WAIT_CYCLES = POWER_WAIT_US * CLOCK_MHZ;

  // distributed refresh: one row per interval, longest time rounds down
  localparam int REFRESH_PERIOD_MS = 16;
  localparam int ROW_COUNT         = 1024;
  localparam int REFRESH_INT       = (REFRESH_PERIOD_MS * 1000 * CLOCK_MHZ) / ROW_COUNT;
  localparam logic [8:0]  REFRESH_LAST = 9'(REFRESH_INT - 1);

  localparam logic [3:0]  WAKE_CYCLES  = 4'h8;

  // least times round up to whole cycles
  localparam int RAS_MIN_NS        = 60;
  localparam int PRECHARGE_NS      = 40;
  localparam int SELF_ENTRY_US     = 100;
  localparam int SELF_EXIT_NS      = 130;
  localparam logic [15:0] RAS_LAST        = 16'((RAS_MIN_NS + CLOCK_NS - 1) / CLOCK_NS - 1);
  localparam logic [15:0] PRECHARGE_LAST  = 16'((PRECHARGE_NS + CLOCK_NS - 1) / CLOCK_NS - 1);
  localparam logic [15:0] SELF_ENTRY_LAST = 16'(SELF_ENTRY_US * CLOCK_MHZ - 1);
  localparam logic [15:0] SELF_EXIT_LAST  = 16'((SELF_EXIT_NS + CLOCK_NS - 1) / CLOCK_NS - 1);
  // column strobe low time, covers the two-flop data path
  localparam logic [15:0] CAS_HOLD_LAST   = 16'h0002;

  typedef enum logic [10:0] {
    ST_POWER     = 11'h001,
    ST_IDLE      = 11'h002,
    ST_CBR_CAS   = 11'h004,
    ST_CBR_RAS   = 11'h008,
    ST_SELF      = 11'h010,
    ST_SELF_EXIT = 11'h020,
    ST_ROW       = 11'h040,
    ST_COL       = 11'h080,
    ST_CAS       = 11'h100,
    ST_HOLD      = 11'h200,
    ST_PRECHARGE = 11'h400
  } state_t;

  typedef struct packed {
    state_t              st;
    logic [15:0]         cnt;
    logic [8:0]          ref_cnt;
    logic                ref_pend;
    logic [3:0]          wake;
    logic                init_done;
    logic                self_on;
    logic                rdy;
    logic [ADDR_W-1:0]   addr;
    logic [ADDR_W-1:0]   col;
    logic                wr;
    logic [1:0]          be;
    logic                ras_n;
    logic                low_byte_column_strobe_n_n;
    logic                high_byte_column_strobe_n_n;
    logic                we_n;
    logic                oe_n;
    logic [DATA_W-1:0]   dout;
    logic                doe;
    logic [DATA_W-1:0]   rdata;
    logic                ack;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{
    st: ST_POWER, cnt: 16'h0000, ref_cnt: 9'h000, ref_pend: 1'b0, wake: 4'h0,
    init_done: 1'b0, self_on: 1'b0, rdy: 1'b0, addr: 10'h000, col: 10'h000, wr: 1'b0, be: 2'h0,
    ras_n: 1'b1, low_byte_column_strobe_n_n: 1'b1, high_byte_column_strobe_n_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
    dout: 16'h0000, doe: 1'b0, rdata: 16'h0000, ack: 1'b0
  };

  typedef struct packed {
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
  } sync_t;

  localparam sync_t SYNC_RESET = '{s1: 16'h0000, s2: 16'h0000};

endpackage

// [core/dram_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module dram_pin_sync
  import dram_refresh_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic [DATA_W-1:0] pin_i,
  output logic      [DATA_W-1:0] sync_o
);

  sync_t q;
  sync_t d;

  // first stage feeds only the second
  always_comb begin
    d    = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      q <= SYNC_RESET;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;

endmodule
`default_nettype wire

// [core/dram_refresh_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_ctrl
  import dram_refresh_pkg::*;
#(
  parameter int POWER_WAIT = POWER_WAIT_CYCLES
)(
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              req_i,
  input  wire logic              write_i,
  input  wire logic [1:0]        byte_en_i,
  input  wire logic [ADDR_W-1:0] row_i,
  input  wire logic [ADDR_W-1:0] col_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              self_refresh_req_i,
  output logic                   ready_o,
  output logic                   ack_o,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   init_done_o,
  output logic                   in_self_refresh_o,
  output logic      [ADDR_W-1:0] mux_address_lines_o,
  output logic                   row_strobe_n_o,
  output logic                   low_byte_column_strobe_n_o,
  output logic                   high_byte_column_strobe_n_o,
  output logic                   write_enable_n_o,
  output logic                   output_enable_n_o,
  output logic      [DATA_W-1:0] data_o,
  output logic                   data_oe_o,
  input  wire logic [DATA_W-1:0] data_i
);

  localparam logic [15:0] POWER_LAST = 16'(POWER_WAIT - 1);

  ctl_t              q;
  ctl_t              d;
  logic [DATA_W-1:0] data_sync;
  logic              timer_on;
  logic              overdue;

  // data pins pass two flops before capture
  dram_pin_sync u_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .pin_i   (data_i),
    .sync_o  (data_sync)
  );

  // sequencer, refresh timer and wake-up bookkeeping
  always_comb begin
    d        = q;
    d.ack    = 1'b0;
    overdue  = 1'b0;
    timer_on = 1'b0;
    case (q.st)
      ST_POWER: begin
        if (q.cnt == POWER_LAST) begin
          d.st   = ST_IDLE;
          d.wake = WAKE_CYCLES;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end
      ST_IDLE: begin
        if (q.rdy && req_i) begin
          d.st   = ST_ROW;
          d.addr = row_i;
          d.col  = col_i;
          d.wr   = write_i;
          d.be   = byte_en_i;
          d.dout = wdata_i;
        end else if (q.wake != 4'h0 || q.ref_pend || self_refresh_req_i) begin
          // both column strobes go low a cycle before the row strobe
          d.st     = ST_CBR_CAS;
          d.low_byte_column_strobe_n_n = 1'b0;
          d.high_byte_column_strobe_n_n = 1'b0;
        end
      end
      ST_CBR_CAS: begin
        d.ras_n    = 1'b0;
        d.st       = ST_CBR_RAS;
        d.cnt      = RAS_LAST;
        d.ref_pend = 1'b0;
        if (q.wake != 4'h0) begin
          d.wake = q.wake - 4'h1;
        end
      end
      ST_CBR_RAS: begin
        if (q.cnt != 16'h0000) begin
          d.cnt = q.cnt - 16'h0001;
        end else if (self_refresh_req_i && q.wake == 4'h0) begin
          d.st  = ST_SELF;
          d.cnt = SELF_ENTRY_LAST;
        end else begin
          d.ras_n  = 1'b1;
          d.low_byte_column_strobe_n_n = 1'b1;
          d.high_byte_column_strobe_n_n = 1'b1;
          d.st     = ST_PRECHARGE;
          d.cnt    = PRECHARGE_LAST;
        end
      end
      // row strobe stays low; the memory keeps itself refreshed
      ST_SELF: begin
        if (q.cnt != 16'h0000) begin
          d.cnt = q.cnt - 16'h0001;
        end else begin
          d.self_on = 1'b1;
        end
        if (!self_refresh_req_i) begin
          d.ras_n  = 1'b1;
          d.low_byte_column_strobe_n_n = 1'b1;
          d.high_byte_column_strobe_n_n = 1'b1;
          d.st     = ST_SELF_EXIT;
          d.cnt    = SELF_EXIT_LAST;
        end
      end
      // row strobe high long enough for an internal refresh to finish
      ST_SELF_EXIT: begin
        if (q.cnt != 16'h0000) begin
          d.cnt = q.cnt - 16'h0001;
        end else begin
          d.self_on = 1'b0;
          d.ref_cnt = 9'h000;
          d.st      = ST_IDLE;
        end
      end
      // row address has stood a full cycle before the row strobe falls
      ST_ROW: begin
        d.ras_n = 1'b0;
        d.st    = ST_COL;
      end
      // column address, direction and data settle a cycle before the column fall
      ST_COL: begin
        d.addr = q.col;
        d.we_n = ~q.wr;
        d.oe_n = q.wr;
        d.doe  = q.wr;
        d.st   = ST_CAS;
      end
      ST_CAS: begin
        d.low_byte_column_strobe_n_n = ~q.be[0];
        d.high_byte_column_strobe_n_n = ~q.be[1];
        d.cnt    = CAS_HOLD_LAST;
        d.st     = ST_HOLD;
      end
      // wait out the two-flop data path, then take the word and close the row
      ST_HOLD: begin
        if (q.cnt != 16'h0000) begin
          d.cnt = q.cnt - 16'h0001;
        end else begin
          if (!q.wr) begin
            d.rdata = data_sync;
          end
          d.ack    = 1'b1;
          d.ras_n  = 1'b1;
          d.low_byte_column_strobe_n_n = 1'b1;
          d.high_byte_column_strobe_n_n = 1'b1;
          d.we_n   = 1'b1;
          d.oe_n   = 1'b1;
          d.doe    = 1'b0;
          d.st     = ST_PRECHARGE;
          d.cnt    = PRECHARGE_LAST;
        end
      end
      // row precharge; the last wake-up cycle opens the block for use
      ST_PRECHARGE: begin
        if (q.cnt != 16'h0000) begin
          d.cnt = q.cnt - 16'h0001;
        end else begin
          d.st = ST_IDLE;
          if (q.wake == 4'h0) begin
            d.init_done = 1'b1;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // refresh timer paused in self-refresh, where the memory refreshes itself
    timer_on = q.init_done && (q.st != ST_SELF) && (q.st != ST_SELF_EXIT);
    if (timer_on) begin
      if (q.ref_cnt == REFRESH_LAST) begin
        d.ref_cnt  = 9'h000;
        d.ref_pend = 1'b1;
        overdue    = q.ref_pend;
      end else begin
        d.ref_cnt = q.ref_cnt + 9'h001;
      end
    end
    // a whole interval missed: rows may have decayed, so wake up again
    if (overdue) begin
      d.wake = WAKE_CYCLES;
    end
    d.rdy = (d.st == ST_IDLE) && d.init_done && (d.wake == 4'h0) && !d.ref_pend && !self_refresh_req_i;
  end

  // state register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      q <= CTL_RESET;
    end else begin
      q <= d;
    end
  end

  // every output straight from a flop
  assign ready_o                     = q.rdy;
  assign ack_o                       = q.ack;
  assign rdata_o                     = q.rdata;
  assign init_done_o                 = q.init_done;
  assign in_self_refresh_o           = q.self_on;
  assign mux_address_lines_o         = q.addr;
  assign row_strobe_n_o              = q.ras_n;
  assign low_byte_column_strobe_n_o  = q.low_byte_column_strobe_n_n;
  assign high_byte_column_strobe_n_o = q.high_byte_column_strobe_n_n;
  assign write_enable_n_o            = q.we_n;
  assign output_enable_n_o           = q.oe_n;
  assign data_o                      = q.dout;
  assign data_oe_o                   = q.doe;

  // row strobe rests high through the power-up pause
  AST_POWER_RAS_HIGH: assert property (
    @(posedge clock_i) disable iff (reset_i) (q.st == ST_POWER) |-> row_strobe_n_o)
    else $error("row strobe low during power-up pause");

  // a refresh row fall finds a column strobe already low
  AST_CBR_CAS_FIRST: assert property (
    @(posedge clock_i) disable iff (reset_i) ($fell(row_strobe_n_o) && q.st == ST_CBR_RAS)
    |-> (!$past(low_byte_column_strobe_n_o) || !$past(high_byte_column_strobe_n_o)))
    else $error("refresh row fall without a column strobe low");

  // an access row fall must not look like a refresh
  AST_ACCESS_CAS_HIGH: assert property (
    @(posedge clock_i) disable iff (reset_i) ($fell(row_strobe_n_o) && q.st == ST_COL)
    |-> ($past(low_byte_column_strobe_n_o) && $past(high_byte_column_strobe_n_o)))
    else $error("access row fall with a column strobe low");

  // every expired interval raises a refresh request
  AST_REFRESH_DUE: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (q.init_done && q.ref_cnt == REFRESH_LAST && q.st != ST_SELF && q.st != ST_SELF_EXIT) |=> q.ref_pend)
    else $error("refresh interval expired without a request");

  // self-refresh holds the row strobe low
  AST_SELF_RAS_LOW: assert property (
    @(posedge clock_i) disable iff (reset_i) (q.st == ST_SELF) |-> !row_strobe_n_o)
    else $error("row strobe high inside self-refresh");

  // leaving self-refresh keeps the row strobe high
  AST_SELF_EXIT_RAS: assert property (
    @(posedge clock_i) disable iff (reset_i) (q.st == ST_SELF_EXIT) |-> row_strobe_n_o)
    else $error("row strobe low during self-refresh exit");

  // no access is offered before the wake-up cycles are done
  AST_READY_AFTER_WAKE: assert property (
    @(posedge clock_i) disable iff (reset_i) ready_o |-> init_done_o)
    else $error("ready raised before wake-up finished");

  // acknowledge is a single-cycle pulse
  AST_ACK_PULSE: assert property (
    @(posedge clock_i) disable iff (reset_i) ack_o |=> !ack_o)
    else $error("acknowledge held longer than one cycle");

endmodule
`default_nettype wire

// [test/dram_device_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dram_device_model
  import dram_refresh_pkg::*;
(
  input  wire logic              ras_n_i,
  input  wire logic              low_byte_column_strobe_n_n_i,
  input  wire logic              high_byte_column_strobe_n_n_i,
  input  wire logic              we_n_i,
  input  wire logic              oe_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] din_i,
  output logic      [DATA_W-1:0] dq_o
);
  logic [DATA_W-1:0] mem [64] = '{default: 16'hffff};
  logic [ADDR_W-1:0] row_q = '0;
  logic [ADDR_W-1:0] ctr_q = '0;
  logic [DATA_W-1:0] held_q = '0;
  logic              cbr_q = 0;
  logic              rd_q = 0;
  int                n_cbr = 0;
  int                n_ras = 0;
  // row fall: column low first means refresh from the counter
  always @(negedge ras_n_i) begin
    n_ras++;
    cbr_q = !(low_byte_column_strobe_n_n_i && high_byte_column_strobe_n_n_i);
    rd_q = 0;
    if (cbr_q) begin
      row_q = ctr_q;
      ctr_q = ctr_q + 1;
      n_cbr++;
    end else
      row_q = addr_i;
  end
  // column fall: settle both lanes, then write bytes or fetch held word
  always @(negedge low_byte_column_strobe_n_n_i or negedge high_byte_column_strobe_n_n_i) begin
    #1;
    if (!ras_n_i && !cbr_q) begin
      if (!we_n_i) begin
        if (!low_byte_column_strobe_n_n_i) mem[{row_q[1:0], addr_i[3:0]}][7:0] = din_i[7:0];
        if (!high_byte_column_strobe_n_n_i) mem[{row_q[1:0], addr_i[3:0]}][15:8] = din_i[15:8];
      end else begin
        held_q = mem[{row_q[1:0], addr_i[3:0]}];
        rd_q = 1;
      end
    end
  end
  // undriven bus shows the inverse so stale data never passes
  assign dq_o = (!ras_n_i && rd_q && !oe_n_i && !cbr_q) ? held_q : ~held_q;
endmodule
`default_nettype wire

// [test/tb_dram_refresh_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_dram_refresh_ctrl import dram_refresh_pkg::*; ;
  localparam int PW = 50;
  logic clock_i = 0, reset_i = 1, req = 0, wr = 0, srr = 0;
  logic [1:0] be = 2'h3;
  logic [ADDR_W-1:0] row = '0, col = '0, addr;
  logic [DATA_W-1:0] wd = '0, rd, dout, dq;
  logic rdy, ack, idn, isr, ras, lc, uc, we, oe;
  int n_fail = 0, cmp_count = 0;
  // free-running clock
  always #20 clock_i = ~clock_i;
  dram_refresh_ctrl #(.POWER_WAIT(PW)) uut (.clock_i(clock_i), .reset_i(reset_i), .req_i(req),
    .write_i(wr), .byte_en_i(be), .row_i(row), .col_i(col), .wdata_i(wd), .self_refresh_req_i(srr),
    .ready_o(rdy), .ack_o(ack), .rdata_o(rd), .init_done_o(idn), .in_self_refresh_o(isr),
    .mux_address_lines_o(addr), .row_strobe_n_o(ras), .low_byte_column_strobe_n_o(lc),
    .high_byte_column_strobe_n_o(uc), .write_enable_n_o(we), .output_enable_n_o(oe),
    .data_o(dout), .data_oe_o(), .data_i(dq));
  dram_device_model dev (.ras_n_i(ras), .low_byte_column_strobe_n_n_i(lc), .high_byte_column_strobe_n_n_i(uc), .we_n_i(we), .oe_n_i(oe),
    .addr_i(addr), .din_i(dout), .dq_o(dq));
  task automatic summarize();
    $display("cmp_count=%0d n_fail=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until the acknowledge edge, read data taken there
  task automatic acc(input logic w, input logic [1:0] b, input logic [9:0] r, c, input logic [15:0] d, e);
    int i;
    @(negedge clock_i);
    req = 1; wr = w; be = b; row = r; col = c; wd = d;
    for (i = 0; i < 300; i++) begin
      @(posedge clock_i);
      #1;
      if (ack === 1'b1) break;
    end
    chk(16'(ack), 16'h1);
    if (!w) chk(rd, e);
    @(negedge clock_i);
    req = 0;
  endtask
  task automatic t_power();
    int i;
    repeat (PW - 2) @(negedge clock_i);
    chk(16'(dev.n_ras), 16'h0);
    chk(16'(ras), 16'h1);
    for (i = 0; i < 2000 && idn !== 1'b1; i++) @(negedge clock_i);
    chk(16'(dev.n_ras >= 8), 16'h1);
  endtask
  task automatic t_page();
    acc(1, 2'h3, 10'h001, 10'h003, 16'ha5c3, 0);
    acc(1, 2'h2, 10'h001, 10'h003, 16'h7e00, 0);
    acc(1, 2'h1, 10'h002, 10'h003, 16'h1234, 0);
    acc(0, 2'h3, 10'h001, 10'h003, 0, 16'h7ec3);
    acc(0, 2'h3, 10'h002, 10'h003, 0, 16'hff34);
  endtask
  task automatic t_refresh();
    int n;
    n = dev.n_cbr;
    repeat (2 * REFRESH_INT + 40) @(negedge clock_i);
    chk(16'(dev.n_cbr - n >= 2), 16'h1);
    acc(0, 2'h3, 10'h001, 10'h003, 0, 16'h7ec3);
  endtask
  task automatic t_self();
    int i;
    @(negedge clock_i);
    srr = 1;
    for (i = 0; i < 4000 && isr !== 1'b1; i++) @(negedge clock_i);
    chk(16'({isr, ras}), 16'h2);
    srr = 0;
    for (i = 0; i < 200 && isr !== 1'b0; i++) @(negedge clock_i);
    chk(16'({isr, ras}), 16'h1);
    acc(0, 2'h3, 10'h002, 10'h003, 0, 16'hff34);
  endtask
  initial begin
    repeat (8) @(negedge clock_i);
    reset_i = 0;
    t_power();
    t_page();
    t_refresh();
    t_self();
    summarize();
  end
  // cut a hang short well past the expected run length
  initial begin
    #400000;
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
